// ==== logic/scp_program_port.sv ====
// Programming front end of an integer-N synthesizer: serial, parallel and
// direct loading of divider settings, primary/secondary banking, hop transfer.
// Assumes all pins are asynchronous to i_mclk; serial shifting runs on i_sclk.
`default_nettype none

module scp_program_port (
  input  wire logic                          i_mclk,
  input  wire logic                          i_srst,
  input  wire logic                          i_sclk,
  input  wire logic                          i_sdata,
  input  wire logic                          i_serial_load,
  input  wire logic                          i_enh_write,
  input  wire logic                          i_serial_bank_select,
  input  wire logic                          i_parallel_bank_select,
  input  wire logic                          i_upper_write_strobe,
  input  wire logic                          i_middle_write_strobe,
  input  wire logic                          i_low_write_strobe,
  input  wire logic                          i_hop_write_strobe,
  input  wire logic [scp_pkg::BUS_W-1:0]     i_pbus,
  input  wire logic                          i_serial_sel,
  input  wire logic                          i_direct_sel,
  input  wire logic [scp_pkg::DREF_W-1:0]    i_direct_ref,
  input  wire logic [scp_pkg::DMAIN_W-1:0]   i_direct_main,
  input  wire logic [scp_pkg::DSWAL_W-1:0]   i_direct_swallow,
  input  wire logic                          i_direct_pre_en_n,
  input  wire logic                          i_enh_func_n,
  output logic      [scp_pkg::REF_W-1:0]     o_ref_div,
  output logic      [scp_pkg::MAIN_W-1:0]    o_main_div,
  output logic      [scp_pkg::SWAL_W-1:0]    o_swallow,
  output logic                               o_prescaler_en_n,
  output logic                               o_prescaler_bypass,
  output logic      [scp_pkg::ENH_W-1:0]     o_enh_bits,
  output logic                               o_enh_active,
  output scp_pkg::scp_mode_t                 o_mode
);
  import scp_pkg::*;

  initial begin
    if (PRESC_DIV_HI != PRESC_DIV_LO + 1) begin
      $error("scp_program_port: prescaler ratios must differ by one");
    end
  end

  // Serial clock domain
  logic             sclk_rst;
  logic [PRI_W-1:0] ser_pri_word;
  logic [ENH_W-1:0] ser_enh_word;
  logic             ser_pri_tgl;
  logic             ser_enh_tgl;

  // Reset reaches the shift clock domain only while the host clocks it
  scp_sync #(
    .W      (1),
    .STAGES (SYNC_STAGES)
  ) u_sclk_rst_sync (
    .i_clk   (i_sclk),
    .i_rst   (1'b0),
    .i_async (i_srst),
    .o_sync  (sclk_rst)
  );

  scp_serial_shift u_shift (
    .i_sclk     (i_sclk),
    .i_rst      (sclk_rst),
    .i_sdata    (i_sdata),
    .i_load_n   (i_serial_load),
    .i_enh_sel  (i_enh_write),
    .o_pri_word (ser_pri_word),
    .o_enh_word (ser_enh_word),
    .o_pri_tgl  (ser_pri_tgl),
    .o_enh_tgl  (ser_enh_tgl)
  );

  // Pin synchronisation into i_mclk
  localparam int CTL_W  = 14;
  localparam int DATA_W = BUS_W + DREF_W + DMAIN_W + DSWAL_W;

  logic [CTL_W-1:0]   ctl_s;
  logic [DATA_W-1:0]  data_s;

  scp_sync #(
    .W      (CTL_W),
    .STAGES (SYNC_STAGES)
  ) u_ctl_sync (
    .i_clk   (i_mclk),
    .i_rst   (i_srst),
    .i_async ({i_serial_load, i_hop_write_strobe, i_upper_write_strobe,
               i_middle_write_strobe, i_low_write_strobe, i_enh_write,
               ser_pri_tgl, ser_enh_tgl, i_serial_bank_select,
               i_parallel_bank_select, i_serial_sel, i_direct_sel,
               i_direct_pre_en_n, ~i_enh_func_n}),  // Inverted: a reset stage reads inactive
    .o_sync  (ctl_s)
  );

  scp_sync #(
    .W      (DATA_W),
    .STAGES (SYNC_STAGES)
  ) u_data_sync (
    .i_clk   (i_mclk),
    .i_rst   (i_srst),
    .i_async ({i_pbus, i_direct_ref, i_direct_main, i_direct_swallow}),
    .o_sync  (data_s)
  );

  logic                s_load_s;
  logic                s_hop_s;
  logic                s_upper_s;
  logic                s_mid_s;
  logic                s_low_s;
  logic                s_enh_s;
  logic                s_pri_tgl_s;
  logic                s_enh_tgl_s;
  logic                s_ser_bank_s;
  logic                s_par_bank_s;
  logic                s_ser_sel_s;
  logic                s_dir_sel_s;
  logic                s_dir_pre_s;
  logic                s_enh_on_s;
  logic [BUS_W-1:0]    bus_s;
  logic [DREF_W-1:0]   dref_s;
  logic [DMAIN_W-1:0]  dmain_s;
  logic [DSWAL_W-1:0]  dswal_s;

  assign {s_load_s, s_hop_s, s_upper_s, s_mid_s, s_low_s, s_enh_s,
          s_pri_tgl_s, s_enh_tgl_s, s_ser_bank_s, s_par_bank_s,
          s_ser_sel_s, s_dir_sel_s, s_dir_pre_s, s_enh_on_s} = ctl_s;
  assign {bus_s, dref_s, dmain_s, dswal_s} = data_s;

  // Edge detection on synchronised strobes
  localparam int EDG_W = 8;
  logic [EDG_W-1:0] edge_prev_q;
  logic [EDG_W-1:0] edge_prev_d;
  logic [EDG_W-1:0] edge_now;
  assign edge_now = {s_load_s, s_hop_s, s_upper_s, s_mid_s, s_low_s, s_enh_s,
                     s_pri_tgl_s, s_enh_tgl_s};
  logic load_rise;
  logic hop_rise;
  logic upper_rise;
  logic mid_rise;
  logic low_rise;
  logic enh_rise;
  logic pri_bit_evt;
  logic enh_bit_evt;
  always_comb begin
    edge_prev_d = edge_now;
    load_rise   = edge_now[7] & ~edge_prev_q[7];
    hop_rise    = edge_now[6] & ~edge_prev_q[6];
    upper_rise  = edge_now[5] & ~edge_prev_q[5];
    mid_rise    = edge_now[4] & ~edge_prev_q[4];
    low_rise    = edge_now[3] & ~edge_prev_q[3];
    enh_rise    = edge_now[2] & ~edge_prev_q[2];
    pri_bit_evt = edge_now[1] ^ edge_prev_q[1];
    enh_bit_evt = edge_now[0] ^ edge_prev_q[0];
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      edge_prev_q <= '0;
    end else begin
      edge_prev_q <= edge_prev_d;
    end
  end

  // Mode decode
  scp_mode_t mode;

  always_comb begin
    if (s_dir_sel_s) begin
      mode = SCP_MODE_DIRECT;
    end else if (s_ser_sel_s) begin
      mode = SCP_MODE_SERIAL;
    end else begin
      mode = SCP_MODE_PARALLEL;
    end
  end

  // Program registers
  logic [PRI_W-1:0] pri_q;
  logic [PRI_W-1:0] pri_d;
  logic [PRI_W-1:0] sec_q;
  logic [PRI_W-1:0] sec_d;
  logic [ENH_W-1:0] enh_q;
  logic [ENH_W-1:0] enh_d;

  // The serial word is read only after a bit toggle has crossed; the host
  // clock period far exceeds the sync delay, so the word is stable then.
  always_comb begin
    pri_d = pri_q;
    enh_d = enh_q;
    sec_d = sec_q;
    case (mode)
      SCP_MODE_SERIAL: begin
        if (pri_bit_evt) begin
          pri_d = ser_pri_word;
        end
        if (enh_bit_evt) begin
          enh_d = ser_enh_word;
        end
        // Copy the just-updated word so a coincident last bit is not lost
        if (load_rise || hop_rise) begin
          sec_d = pri_d;
        end
      end
      SCP_MODE_PARALLEL: begin
        if (upper_rise) begin
          pri_d[PRI_UPPER_LSB +: PRI_UPPER_W] = bus_s[PRI_UPPER_W-1:0];
        end
        if (mid_rise) begin
          pri_d[PRI_MID_LSB +: BUS_W] = bus_s;
        end
        if (low_rise) begin
          pri_d[PRI_LOW_LSB +: BUS_W] = bus_s;
        end
        if (enh_rise) begin
          enh_d = bus_s;
        end
        if (hop_rise) begin
          sec_d = pri_d;
        end
      end
      default: begin
        pri_d = pri_q;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      pri_q <= PRI_RST;
      sec_q <= SEC_RST;
      enh_q <= ENH_RST;
    end else begin
      pri_q <= pri_d;
      sec_q <= sec_d;
      enh_q <= enh_d;
    end
  end

  // Counter source selection and field unpacking
  logic [PRI_W-1:0]  src_word;
  logic [REF_W-1:0]  ref_d;
  logic [MAIN_W-1:0] main_d;
  logic [SWAL_W-1:0] swal_d;
  logic              pre_n_d;
  logic [ENH_W-1:0]  enh_bits_d;
  logic              enh_act_d;

  always_comb begin
    src_word = sec_q;
    case (mode)
      SCP_MODE_SERIAL: begin
        src_word = s_ser_bank_s ? pri_q : sec_q;
      end
      SCP_MODE_PARALLEL: begin
        src_word = s_par_bank_s ? pri_q : sec_q;
      end
      default: begin
        src_word = sec_q;
      end
    endcase
    ref_d   = {src_word[PRI_R_HI_LSB +: 2], src_word[PRI_R_LO_LSB +: 4]};
    main_d  = {src_word[PRI_M_HI_LSB +: 2], src_word[PRI_MID_LSB +: DMAIN_W]};
    swal_d  = src_word[PRI_A_LSB +: SWAL_W];
    pre_n_d = src_word[PRI_PRE_BIT];
    if (mode == SCP_MODE_DIRECT) begin
      ref_d   = {2'h0, dref_s};
      main_d  = {2'h0, dmain_s};
      swal_d  = dswal_s;
      pre_n_d = s_dir_pre_s;
    end
    // Direct mode has no enhancement pin path, so the bits stay inert there
    enh_act_d  = s_enh_on_s && (mode != SCP_MODE_DIRECT);
    enh_bits_d = enh_act_d ? enh_q : ENH_RST;
  end

  // Output registers; counters are refreshed every cycle from the source
  logic [REF_W-1:0]  ref_q;
  logic [MAIN_W-1:0] main_q;
  logic [SWAL_W-1:0] swal_q;
  logic              pre_n_q;
  logic              bypass_q;
  logic [ENH_W-1:0]  enh_bits_q;
  logic              enh_act_q;
  scp_mode_t         mode_q;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      ref_q      <= '0;
      main_q     <= '0;
      swal_q     <= '0;
      pre_n_q    <= 1'b1;
      bypass_q   <= 1'b1;
      enh_bits_q <= ENH_RST;
      enh_act_q  <= 1'b0;
      mode_q     <= SCP_MODE_PARALLEL;
    end else begin
      ref_q      <= ref_d;
      main_q     <= main_d;
      swal_q     <= swal_d;
      pre_n_q    <= pre_n_d;
      bypass_q   <= pre_n_d;
      enh_bits_q <= enh_bits_d;
      enh_act_q  <= enh_act_d;
      mode_q     <= mode;
    end
  end

  assign o_ref_div          = ref_q;
  assign o_main_div         = main_q;
  assign o_swallow          = swal_q;
  assign o_prescaler_en_n   = pre_n_q;
  assign o_prescaler_bypass = bypass_q;
  assign o_enh_bits         = enh_bits_q;
  assign o_enh_active       = enh_act_q;
  assign o_mode             = mode_q;

endmodule

`default_nettype wire

// ==== logic/scp_pkg.sv ====
// Shared constants for the synthesizer counter program port.
// Assumes nothing beyond a SystemVerilog-2012 elaborator.
`default_nettype none

package scp_pkg;

  // Register widths
  localparam int PRI_W = 20;
  localparam int ENH_W = 8;
  localparam int BUS_W = 8;

  // Primary word layout: {R[5:4],M[8:7]} | {pre_en_n,M[6:0]} | {R[3:0],A[3:0]}
  localparam int PRI_UPPER_LSB = 16;
  localparam int PRI_UPPER_W   = 4;
  localparam int PRI_MID_LSB   = 8;
  localparam int PRI_LOW_LSB   = 0;
  localparam int PRI_PRE_BIT   = 15;
  localparam int PRI_R_HI_LSB  = 18;
  localparam int PRI_M_HI_LSB  = 16;
  localparam int PRI_R_LO_LSB  = 4;
  localparam int PRI_A_LSB     = 0;

  // Counter field widths
  localparam int REF_W     = 6;
  localparam int MAIN_W    = 9;
  localparam int SWAL_W    = 4;
  localparam int DREF_W    = 4;
  localparam int DMAIN_W   = 7;
  localparam int DSWAL_W   = 4;

  // Dual-modulus prescaler ratios
  localparam int PRESC_DIV_LO = 10;
  localparam int PRESC_DIV_HI = 11;

  // Synchroniser depth
  localparam int SYNC_STAGES = 2;

  // Reset values
  localparam logic [PRI_W-1:0] PRI_RST = 20'h08000;
  localparam logic [PRI_W-1:0] SEC_RST = 20'h08000;
  localparam logic [ENH_W-1:0] ENH_RST = 8'h00;

  typedef enum logic [1:0] {
    SCP_MODE_SERIAL,
    SCP_MODE_PARALLEL,
    SCP_MODE_DIRECT
  } scp_mode_t;

endpackage

`default_nettype wire

// ==== logic/scp_sync.sv ====
// Multi-bit level synchroniser, one chain of flops per bit.
// Assumes each bit is an independent level; words must be stable when used.
`default_nettype none

module scp_sync #(
  parameter int W      = 1,
  parameter int STAGES = scp_pkg::SYNC_STAGES
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  import scp_pkg::*;

  initial begin
    if (W < 1 || STAGES < 2) begin
      $error("scp_sync: bad width or stage count");
    end
  end

  logic [W-1:0] stage_q [STAGES];
  logic [W-1:0] stage_d [STAGES];

  always_comb begin
    stage_d[0] = i_async;
    for (int i = 1; i < STAGES; i++) begin
      stage_d[i] = stage_q[i-1];
    end
  end

  always_ff @(posedge i_clk) begin
    for (int i = 0; i < STAGES; i++) begin
      if (i_rst) begin
        stage_q[i] <= '0;
      end else begin
        stage_q[i] <= stage_d[i];
      end
    end
  end

  assign o_sync = stage_q[STAGES-1];

endmodule

`default_nettype wire

// ==== logic/scp_serial_shift.sv ====
// Serial shift registers on the host's shift clock.
// Assumes the shift clock runs only during frames; each accepted bit flips a
// toggle so the system-clock side sees one event per bit.
`default_nettype none

module scp_serial_shift (
  input  wire logic                       i_sclk,
  input  wire logic                       i_rst,
  input  wire logic                       i_sdata,
  input  wire logic                       i_load_n,
  input  wire logic                       i_enh_sel,
  output logic      [scp_pkg::PRI_W-1:0]  o_pri_word,
  output logic      [scp_pkg::ENH_W-1:0]  o_enh_word,
  output logic                            o_pri_tgl,
  output logic                            o_enh_tgl
);
  import scp_pkg::*;

  logic [PRI_W-1:0] pri_q;
  logic [PRI_W-1:0] pri_d;
  logic [ENH_W-1:0] enh_q;
  logic [ENH_W-1:0] enh_d;
  logic             pri_tgl_q;
  logic             pri_tgl_d;
  logic             enh_tgl_q;
  logic             enh_tgl_d;

  always_comb begin
    pri_d     = pri_q;
    enh_d     = enh_q;
    pri_tgl_d = pri_tgl_q;
    enh_tgl_d = enh_tgl_q;
    if (i_enh_sel) begin
      enh_d     = {enh_q[ENH_W-2:0], i_sdata};
      enh_tgl_d = ~enh_tgl_q;
    end else if (!i_load_n) begin
      pri_d     = {pri_q[PRI_W-2:0], i_sdata};
      pri_tgl_d = ~pri_tgl_q;
    end
  end

  always_ff @(posedge i_sclk) begin
    if (i_rst) begin
      pri_q     <= PRI_RST;
      enh_q     <= ENH_RST;
      pri_tgl_q <= 1'b0;
      enh_tgl_q <= 1'b0;
    end else begin
      pri_q     <= pri_d;
      enh_q     <= enh_d;
      pri_tgl_q <= pri_tgl_d;
      enh_tgl_q <= enh_tgl_d;
    end
  end

  assign o_pri_word = pri_q;
  assign o_enh_word = enh_q;
  assign o_pri_tgl  = pri_tgl_q;
  assign o_enh_tgl  = enh_tgl_q;

endmodule

`default_nettype wire

// ==== verification/scp_program_port_asserts.sv ====
// Concurrent checks on the counter program port, bound to its top module.
// Assumes every pin change reaches the outputs within five i_mclk cycles.
`default_nettype none

module scp_program_port_asserts (
  input wire logic               i_mclk,
  input wire logic               i_srst,
  input wire logic               i_sclk,
  input wire logic               i_sdata,
  input wire logic               i_serial_load,
  input wire logic               i_enh_write,
  input wire logic               i_serial_bank_select,
  input wire logic               i_parallel_bank_select,
  input wire logic               i_upper_write_strobe,
  input wire logic               i_middle_write_strobe,
  input wire logic               i_low_write_strobe,
  input wire logic               i_hop_write_strobe,
  input wire logic [7:0]         i_pbus,
  input wire logic               i_serial_sel,
  input wire logic               i_direct_sel,
  input wire logic [3:0]         i_direct_ref,
  input wire logic [6:0]         i_direct_main,
  input wire logic [3:0]         i_direct_swallow,
  input wire logic               i_direct_pre_en_n,
  input wire logic               i_enh_func_n,
  input wire logic [5:0]         o_ref_div,
  input wire logic [8:0]         o_main_div,
  input wire logic [3:0]         o_swallow,
  input wire logic               o_prescaler_en_n,
  input wire logic               o_prescaler_bypass,
  input wire logic [7:0]         o_enh_bits,
  input wire logic               o_enh_active,
  input wire scp_pkg::scp_mode_t o_mode
);
  import scp_pkg::*;

  wire logic [36:0] pins = {i_sclk, i_sdata, i_serial_load, i_enh_write, i_serial_bank_select,
    i_parallel_bank_select, i_upper_write_strobe, i_middle_write_strobe, i_low_write_strobe,
    i_hop_write_strobe, i_pbus, i_serial_sel, i_direct_sel, i_direct_ref, i_direct_main,
    i_direct_swallow, i_direct_pre_en_n, i_enh_func_n};
  wire logic [15:0] dpins = {i_direct_pre_en_n, i_direct_main, i_direct_ref, i_direct_swallow};
  wire logic [31:0] outs = {o_prescaler_bypass, o_mode, o_enh_active, o_enh_bits, o_ref_div,
    o_main_div, o_prescaler_en_n, o_swallow};

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  a_bypass_tracks: assert property (o_prescaler_bypass == o_prescaler_en_n)
    else $error("bypass differs from prescaler enable");
  a_enh_zeroed: assert property (!o_enh_active |-> o_enh_bits == 8'h00)
    else $error("enhancement bits shown while inactive");
  a_enh_pin_off: assert property (i_enh_func_n [*4] |-> !o_enh_active)
    else $error("enhancement active with function pin high");
  a_enh_pin_on: assert property ((!i_enh_func_n && !i_direct_sel) [*5] |-> o_enh_active)
    else $error("enhancement inactive with function pin low");
  a_direct_load: assert property ((i_direct_sel && $stable(dpins)) [*5] |->
    o_ref_div == {2'b00, i_direct_ref} && o_main_div == {2'b00, i_direct_main} &&
    o_swallow == i_direct_swallow && o_prescaler_en_n == i_direct_pre_en_n)
    else $error("direct pins not driving the counters");
  a_mode_decode: assert property ($stable({i_direct_sel, i_serial_sel}) [*5] |->
    o_mode == (i_direct_sel ? SCP_MODE_DIRECT : i_serial_sel ? SCP_MODE_SERIAL : SCP_MODE_PARALLEL))
    else $error("mode does not follow the select pins");
  a_mode_legal: assert property (o_mode inside {SCP_MODE_SERIAL, SCP_MODE_PARALLEL,
    SCP_MODE_DIRECT}) else $error("undefined mode code");
  a_outs_hold: assert property ($stable(pins) [*8] |-> $stable(outs))
    else $error("outputs changed with all pins quiet");

  c_direct: cover property (i_direct_sel [*5]);
  c_enh_on: cover property (!i_enh_func_n && o_enh_active);
  c_serial_copy: cover property ($rose(i_serial_load) && i_serial_sel);
endmodule

bind scp_program_port scp_program_port_asserts i_chk (.i_mclk(i_mclk), .i_srst(i_srst),
  .i_sclk(i_sclk), .i_sdata(i_sdata), .i_serial_load(i_serial_load), .i_enh_write(i_enh_write),
  .i_serial_bank_select(i_serial_bank_select), .i_parallel_bank_select(i_parallel_bank_select),
  .i_upper_write_strobe(i_upper_write_strobe), .i_middle_write_strobe(i_middle_write_strobe),
  .i_low_write_strobe(i_low_write_strobe), .i_hop_write_strobe(i_hop_write_strobe),
  .i_pbus(i_pbus), .i_serial_sel(i_serial_sel), .i_direct_sel(i_direct_sel),
  .i_direct_ref(i_direct_ref), .i_direct_main(i_direct_main),
  .i_direct_swallow(i_direct_swallow), .i_direct_pre_en_n(i_direct_pre_en_n),
  .i_enh_func_n(i_enh_func_n), .o_ref_div(o_ref_div), .o_main_div(o_main_div),
  .o_swallow(o_swallow), .o_prescaler_en_n(o_prescaler_en_n),
  .o_prescaler_bypass(o_prescaler_bypass), .o_enh_bits(o_enh_bits),
  .o_enh_active(o_enh_active), .o_mode(o_mode));

`default_nettype wire

// ==== verification/scp_host_model.sv ====
// Host model of the serial link: shift clock, data, load strobe and enhancement select.
// Assumes the caller lets send return before it changes the mode pins.
`default_nettype none

module scp_host_model (
  output var logic o_sclk,
  output var logic o_sdata,
  output var logic o_serial_load,
  output var logic o_enh_write
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_sclk = 1'b0;
    o_sdata = 1'b0;
    o_serial_load = 1'b1;
    o_enh_write = 1'b0;
  end

  // Send runs the shift clock only inside a frame; from a start 1 ns after a system edge the 7 ns skew puts it on the system rising edges
  task automatic send(input logic [19:0] w, input int n, input logic enh);
    #7;
    o_enh_write = enh;
    o_serial_load = enh;  // Load held low across a primary frame
    #40;
    for (int k = n - 1; k >= 0; k--) begin
      o_sdata = w[k];
      #40 o_sclk = 1'b1;
      #40 o_sclk = 1'b0;
    end
    #40;
    o_serial_load = 1'b1;  // Rising edge moves primary into secondary
    o_enh_write = 1'b0;
    o_sdata = ~o_sdata;  // A released data line does not keep its last value
  endtask

  // Idle pulses let a held reset reach the shift clock domain; load stays high, no bit lands
  task automatic idle(input int n);
    for (int k = 0; k < n; k++) begin
      #40 o_sclk = 1'b1;
      #40 o_sclk = 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// ==== verification/scp_program_port_test.sv ====
// Self-checking bench for the counter program port: parallel, serial and direct loading.
// Assumes the host model owns the serial link and this bench drives all other pins.
`default_nettype none

module scp_program_port_test;
  import scp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_mclk = 1'b0;
  logic        i_srst = 1'b1;
  logic [4:0]  stb = 5'h00;
  logic        sbank = 1'b0;
  logic        pbank = 1'b0;
  logic        ssel = 1'b0;
  logic        dsel = 1'b0;
  logic        func_n = 1'b1;
  logic [7:0]  pbus = 8'h00;
  logic [15:0] dpins = 16'h0000;
  wire logic   sclk, sdata, sload, henh;
  wire logic   enh_wr = henh | stb[3];
  wire logic [31:0] snap;
  logic [31:0] exp_q[$];
  int          err_count = 0;
  int          n_compared = 0;
  event        snap_ev;

  always #4 i_mclk = ~i_mclk;

  scp_host_model i_host (.o_sclk(sclk), .o_sdata(sdata), .o_serial_load(sload),
    .o_enh_write(henh));

  scp_program_port i_dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_sclk(sclk), .i_sdata(sdata),
    .i_serial_load(sload), .i_enh_write(enh_wr), .i_serial_bank_select(sbank),
    .i_parallel_bank_select(pbank), .i_upper_write_strobe(stb[0]),
    .i_middle_write_strobe(stb[1]), .i_low_write_strobe(stb[2]), .i_hop_write_strobe(stb[4]),
    .i_pbus(pbus), .i_serial_sel(ssel), .i_direct_sel(dsel), .i_direct_ref(dpins[7:4]),
    .i_direct_main(dpins[14:8]), .i_direct_swallow(dpins[3:0]),
    .i_direct_pre_en_n(dpins[15]), .i_enh_func_n(func_n), .o_ref_div(snap[19:14]),
    .o_main_div(snap[13:5]), .o_swallow(snap[3:0]), .o_prescaler_en_n(snap[4]),
    .o_prescaler_bypass(snap[31]), .o_enh_bits(snap[27:20]), .o_enh_active(snap[28]),
    .o_mode(snap[30:29]));

  // Counters as the primary word lays them out; bypass mirrors the enable
  function automatic logic [31:0] exp_of(input scp_mode_t md, input logic [8:0] enh,
                                         input logic [19:0] p);
    return {p[15], md, enh, p[19:18], p[7:4], p[17:16], p[14:8], p[15], p[3:0]};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  // Eight cycles cover the worst pin-to-output latency of five
  task automatic expect_out(input scp_mode_t md, input logic [8:0] enh, input logic [19:0] p);
    exp_q.push_back(exp_of(md, enh, p));
    cyc(8);
    ->snap_ev;
    cyc(1);
  endtask

  task automatic check_snap(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t ns: outputs %h, expected %h", $time, g, e);
    end
  endtask

  always @(snap_ev) begin
    if (exp_q.size() > 0)
      check_snap(exp_q.pop_front(), snap);
  end

  // Bus stays put three cycles either side of the strobe edge
  task automatic pwrite(input int k, input logic [7:0] d);
    pbus = d;
    cyc(3);
    stb[k] = 1'b1;
    cyc(3);
    stb[k] = 1'b0;
    pbus = ~d;
    cyc(3);
  endtask

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #100us;
    err_count++;
    complete_run();
  end

  initial begin
    logic [19:0] p;
    logic [19:0] s;
    logic [7:0]  e;
    logic [7:0]  d;
    void'($urandom(32'hbc8402ca));
    p = PRI_RST;
    s = SEC_RST;
    e = ENH_RST;
    cyc(4);
    i_srst = 1'b0;
    cyc(2);
    // Second reset spans shift clock edges so the shift domain clears as well
    i_srst = 1'b1;
    i_host.idle(3);
    cyc(1);
    i_srst = 1'b0;
    i_host.idle(2);
    cyc(1);
    expect_out(SCP_MODE_PARALLEL, 9'h000, s);
    pbank = 1'b1;
    for (int k = 0; k < 3; k++) begin
      d = 8'($urandom);
      pwrite(k, d);
      case (k)
        0: p[19:16] = d[3:0];
        1: p[15:8] = d;
        default: p[7:0] = d;
      endcase
    end
    expect_out(SCP_MODE_PARALLEL, 9'h000, p);
    pbank = 1'b0;
    expect_out(SCP_MODE_PARALLEL, 9'h000, s);
    pwrite(4, 8'($urandom));
    s = p;
    expect_out(SCP_MODE_PARALLEL, 9'h000, s);
    func_n = 1'b0;
    e = 8'($urandom);
    pwrite(3, e);
    expect_out(SCP_MODE_PARALLEL, {1'b1, e}, s);
    func_n = 1'b1;
    expect_out(SCP_MODE_PARALLEL, 9'h000, s);
    ssel = 1'b1;
    func_n = 1'b0;
    p = 20'($urandom);
    i_host.send(p, 20, 1'b0);
    s = p;
    expect_out(SCP_MODE_SERIAL, {1'b1, e}, s);
    sbank = 1'b1;
    e = 8'($urandom);
    i_host.send({12'h000, e}, 8, 1'b1);
    expect_out(SCP_MODE_SERIAL, {1'b1, e}, p);
    ssel = 1'b0;
    cyc(2);
    d = 8'($urandom);
    pwrite(2, d);
    p[7:0] = d;
    ssel = 1'b1;
    pwrite(1, 8'($urandom));
    expect_out(SCP_MODE_SERIAL, {1'b1, e}, p);
    sbank = 1'b0;
    expect_out(SCP_MODE_SERIAL, {1'b1, e}, s);
    pwrite(4, 8'($urandom));
    s = p;
    expect_out(SCP_MODE_SERIAL, {1'b1, e}, s);
    dsel = 1'b1;
    for (int k = 0; k < 3; k++) begin
      dpins = 16'($urandom);
      expect_out(SCP_MODE_DIRECT, 9'h000, {4'h0, dpins});
    end
    dsel = 1'b0;
    expect_out(SCP_MODE_SERIAL, {1'b1, e}, s);
    complete_run();
  end
endmodule

`default_nettype wire
